// [hw/timer16_defines.vh]
// register offsets, field positions, reset values and mode codes of the 16-bit timer
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// register offsets (word addresses on the plain register port)
`define T16_ADDR_CTRL 8'h00
`define T16_ADDR_FORCE 8'h01
`define T16_ADDR_COUNT 8'h02
`define T16_ADDR_CMP_A 8'h03
`define T16_ADDR_CMP_B 8'h04
`define T16_ADDR_CAPT 8'h05
`define T16_ADDR_FLAGS 8'h06
`define T16_ADDR_PORT 8'h07
`define T16_ADDR_STATUS 8'h08

// control register fields
`define T16_CTRL_WMS_LSB 0
`define T16_CTRL_COMA_LSB 4
`define T16_CTRL_COMB_LSB 6

// flag register bit positions
`define T16_FLAG_OVF 0
`define T16_FLAG_CMPA 1
`define T16_FLAG_CMPB 2
`define T16_FLAG_CAPT 3

// port register bit positions
`define T16_PORT_DATA_A 0
`define T16_PORT_DIR_A 1
`define T16_PORT_DATA_B 2
`define T16_PORT_DIR_B 3

// reset values
`define T16_RST_CTRL 8'h00
`define T16_RST_COUNT 16'h0000
`define T16_RST_CMP 16'h0000
`define T16_RST_CAPT 16'h0000
`define T16_RST_LATCH 1'b0

// waveform mode codes
`define T16_WMS_NORMAL 4'h0
`define T16_WMS_CTC_CMPA 4'h4
`define T16_WMS_FPWM_8 4'h5
`define T16_WMS_FPWM_9 4'h6
`define T16_WMS_FPWM_10 4'h7
`define T16_WMS_CTC_CAPT 4'hc
`define T16_WMS_FPWM_CAPT 4'he
`define T16_WMS_FPWM_CMPA 4'hf

// fixed tops and counter extremes
`define T16_TOP_8 16'h00ff
`define T16_TOP_9 16'h01ff
`define T16_TOP_10 16'h03ff
`define T16_MAX 16'hffff
`define T16_BOTTOM 16'h0000

// compare output mode codes
`define T16_COM_OFF 2'h0
`define T16_COM_TOGGLE 2'h1
`define T16_COM_LOW 2'h2
`define T16_COM_HIGH 2'h3

`endif

// [hw/timer16_compare_channel.v]
// one compare channel: buffered compare value, match detect, flag and output latch
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.vh"

module timer16_compare_channel #(
  parameter WIDTH = 16,
  parameter TOGGLE_IN_PWM = 0
) (
  input wire clk_i,
  input wire nrst_i,
  input wire tick_i,
  input wire [WIDTH-1:0] count_i,
  input wire pwm_i,
  input wire top_tick_i,
  input wire block_i,
  input wire [1:0] mode_i,
  input wire force_i,
  input wire cmp_wr_i,
  input wire [WIDTH-1:0] cmp_wdata_i,
  input wire flag_clr_i,
  output reg [WIDTH-1:0] cmp_buf_o,
  output reg [WIDTH-1:0] cmp_act_o,
  output wire match_o,
  output reg flag_o,
  output reg latch_o
);

  //////////////////////////////////////////////////////////////////////////
  // match is sampled on the timer tick; a counter write masks one tick
  assign match_o = tick_i && !block_i && (count_i == cmp_act_o);

  //////////////////////////////////////////////////////////////////////////
  // compare value: direct in non-pwm modes, reloaded at top in pwm modes
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_buf_o <= `T16_RST_CMP;
      cmp_act_o <= `T16_RST_CMP;
    end else begin
      if (cmp_wr_i) begin
        cmp_buf_o <= cmp_wdata_i;
      end
      if (cmp_wr_i && !pwm_i) begin
        cmp_act_o <= cmp_wdata_i; // unbuffered
      end else if (pwm_i && top_tick_i) begin
        cmp_act_o <= cmp_buf_o;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flag: raised by the unregistered match, on the tick of equality
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (match_o) begin
      flag_o <= 1'b1; // set beats clear
    end else if (flag_clr_i) begin
      flag_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output latch; top event wins over a match in the same tick
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_o <= `T16_RST_LATCH;
    end else if (pwm_i) begin
      if (top_tick_i && mode_i == `T16_COM_LOW) begin
        latch_o <= 1'b0;
      end else if (top_tick_i && mode_i == `T16_COM_HIGH) begin
        latch_o <= 1'b1;
      end else if (match_o) begin
        case (mode_i)
          `T16_COM_TOGGLE: begin
            if (TOGGLE_IN_PWM != 0) begin
              latch_o <= !latch_o;
            end
          end
          `T16_COM_LOW: begin
            latch_o <= 1'b1; // non-inverted
          end
          `T16_COM_HIGH: begin
            latch_o <= 1'b0; // inverted
          end
          default: begin
            latch_o <= latch_o;
          end
        endcase
      end
    end else if (match_o || force_i) begin
      // force acts as a match without flag or counter effect
      case (mode_i)
        `T16_COM_TOGGLE: begin
          latch_o <= !latch_o; // one toggle per match or force strobe
        end
        `T16_COM_LOW: begin
          latch_o <= 1'b0;
        end
        `T16_COM_HIGH: begin
          latch_o <= 1'b1;
        end
        default: begin
          latch_o <= latch_o;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [hw/timer16_waveform.v]
// 16-bit timer/counter with normal, clear-on-match and fast pwm waveform modes
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.vh"

module timer16_waveform #(
  parameter WIDTH = 16,
  parameter AW = 8
) (
  input wire clk_i,
  input wire nrst_i,
  input wire tick_i,
  input wire [AW-1:0] addr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [WIDTH-1:0] rdata_o,
  input wire overflow_serviced_i,
  input wire compare_a_serviced_i,
  input wire compare_b_serviced_i,
  input wire capture_serviced_i,
  output wire overflow_flag_o,
  output wire compare_a_flag_o,
  output wire compare_b_flag_o,
  output wire capture_flag_o,
  input wire pin_a_i,
  output wire pin_a_o,
  output wire pin_a_oe_n_o,
  input wire pin_b_i,
  output wire pin_b_o,
  output wire pin_b_oe_n_o
);

  //////////////////////////////////////////////////////////////////////////
  // mode helpers

  // true for the single-slope pwm modes handled here
  function is_fast_pwm;
    input [3:0] m;
    begin
      is_fast_pwm = (m == `T16_WMS_FPWM_8) || (m == `T16_WMS_FPWM_9) ||
                    (m == `T16_WMS_FPWM_10) || (m == `T16_WMS_FPWM_CAPT) ||
                    (m == `T16_WMS_FPWM_CMPA);
    end
  endfunction

  // true for the clear-on-match modes
  function is_ctc;
    input [3:0] m;
    begin
      is_ctc = (m == `T16_WMS_CTC_CMPA) || (m == `T16_WMS_CTC_CAPT);
    end
  endfunction

  // true when the capture register defines top
  function top_is_capt;
    input [3:0] m;
    begin
      top_is_capt = (m == `T16_WMS_CTC_CAPT) || (m == `T16_WMS_FPWM_CAPT);
    end
  endfunction

  // true when compare a defines top
  function top_is_cmpa;
    input [3:0] m;
    begin
      top_is_cmpa = (m == `T16_WMS_CTC_CMPA) || (m == `T16_WMS_FPWM_CMPA);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // software-visible state and internal flops
  reg [3:0] waveform_mode_select;
  reg [1:0] channel_a_output_mode;
  reg [1:0] channel_b_output_mode;
  reg [WIDTH-1:0] counter_value;
  reg [WIDTH-1:0] capture_value;
  reg overflow_flag;
  reg capture_flag;
  reg port_data_a;
  reg port_data_b;
  reg output_pin_direction_bit_a;
  reg output_pin_direction_bit_b;
  reg block_match;
  reg pin_a_meta;
  reg pin_a_sync;
  reg pin_b_meta;
  reg pin_b_sync;

  wire pwm_mode;
  wire ctc_mode;
  wire [WIDTH-1:0] cmp_a_act;
  wire [WIDTH-1:0] cmp_a_buf;
  wire [WIDTH-1:0] cmp_b_buf;
  wire [WIDTH-1:0] cmp_b_act;
  wire match_a;
  wire match_b;
  wire compare_a_flag;
  wire compare_b_flag;
  wire channel_a_output_latch;
  wire channel_b_output_latch;
  reg [WIDTH-1:0] top_value;
  wire at_top;
  wire top_tick;
  wire at_max;
  wire sel_ctrl;
  wire sel_force;
  wire sel_count;
  wire sel_cmp_a;
  wire sel_cmp_b;
  wire sel_capt;
  wire sel_flags;
  wire sel_port;
  wire force_a;
  wire force_b;
  wire clr_ovf;
  wire clr_cmpa;
  wire clr_cmpb;
  wire clr_capt;
  wire count_wr;

  //////////////////////////////////////////////////////////////////////////
  // address decode of the plain register port
  assign sel_ctrl = (addr_i == `T16_ADDR_CTRL);
  assign sel_force = (addr_i == `T16_ADDR_FORCE);
  assign sel_count = (addr_i == `T16_ADDR_COUNT);
  assign sel_cmp_a = (addr_i == `T16_ADDR_CMP_A);
  assign sel_cmp_b = (addr_i == `T16_ADDR_CMP_B);
  assign sel_capt = (addr_i == `T16_ADDR_CAPT);
  assign sel_flags = (addr_i == `T16_ADDR_FLAGS);
  assign sel_port = (addr_i == `T16_ADDR_PORT);

  assign count_wr = wr_i && sel_count;

  // force strobes are ignored in pwm modes
  assign force_a = wr_i && sel_force && wdata_i[0] && !pwm_mode;
  assign force_b = wr_i && sel_force && wdata_i[1] && !pwm_mode;

  // write-one-to-clear, or the interrupt being serviced
  assign clr_ovf = (wr_i && sel_flags && wdata_i[`T16_FLAG_OVF]) || overflow_serviced_i;
  assign clr_cmpa = (wr_i && sel_flags && wdata_i[`T16_FLAG_CMPA]) || compare_a_serviced_i;
  assign clr_cmpb = (wr_i && sel_flags && wdata_i[`T16_FLAG_CMPB]) || compare_b_serviced_i;
  assign clr_capt = (wr_i && sel_flags && wdata_i[`T16_FLAG_CAPT]) || capture_serviced_i;

  //////////////////////////////////////////////////////////////////////////
  // control and port registers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      waveform_mode_select <= `T16_WMS_NORMAL; // four-bit field, normal mode
      channel_a_output_mode <= `T16_COM_OFF;
      channel_b_output_mode <= `T16_COM_OFF;
      port_data_a <= 1'b0;
      port_data_b <= 1'b0;
      output_pin_direction_bit_a <= 1'b0;
      output_pin_direction_bit_b <= 1'b0;
      capture_value <= `T16_RST_CAPT;
    end else begin
      if (wr_i && sel_ctrl) begin
        // output mode switches the pin source at once; the latch moves from the next match or top onward
        waveform_mode_select <= wdata_i[`T16_CTRL_WMS_LSB +: 4];
        channel_a_output_mode <= wdata_i[`T16_CTRL_COMA_LSB +: 2];
        channel_b_output_mode <= wdata_i[`T16_CTRL_COMB_LSB +: 2];
      end
      if (wr_i && sel_port) begin
        port_data_a <= wdata_i[`T16_PORT_DATA_A];
        output_pin_direction_bit_a <= wdata_i[`T16_PORT_DIR_A];
        port_data_b <= wdata_i[`T16_PORT_DATA_B];
        output_pin_direction_bit_b <= wdata_i[`T16_PORT_DIR_B];
      end
      // capture value written by software; capture logic itself lives elsewhere
      if (wr_i && sel_capt) begin
        capture_value <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // top selection, driven by waveform mode alone
  assign pwm_mode = is_fast_pwm(waveform_mode_select);
  assign ctc_mode = is_ctc(waveform_mode_select);

  always @* begin
    case (waveform_mode_select)
      `T16_WMS_FPWM_8: begin
        top_value = `T16_TOP_8;
      end
      `T16_WMS_FPWM_9: begin
        top_value = `T16_TOP_9;
      end
      `T16_WMS_FPWM_10: begin
        top_value = `T16_TOP_10;
      end
      `T16_WMS_CTC_CAPT, `T16_WMS_FPWM_CAPT: begin
        top_value = capture_value;
      end
      `T16_WMS_CTC_CMPA, `T16_WMS_FPWM_CMPA: begin
        top_value = cmp_a_act; // live in ctc, buffered in pwm
      end
      default: begin
        top_value = `T16_MAX;
      end
    endcase
  end

  // top event only counts in modes that clear the counter
  assign at_top = (ctc_mode || pwm_mode) && (counter_value == top_value);
  assign top_tick = tick_i && at_top;
  assign at_max = (counter_value == `T16_MAX);

  //////////////////////////////////////////////////////////////////////////
  // counter: advances on the prescaled tick only
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      counter_value <= `T16_RST_COUNT;
    end else if (count_wr) begin
      counter_value <= wdata_i;
    end else if (tick_i) begin
      if (at_top) begin
        counter_value <= `T16_BOTTOM; // clears on tick after top
      end else begin
        // wraps max to bottom when top was missed
        counter_value <= counter_value + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // a counter write hides the match of the following tick
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      block_match <= 1'b0;
    end else if (count_wr) begin
      block_match <= 1'b1;
    end else if (tick_i) begin
      block_match <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // overflow and capture flags; set wins over a same-cycle clear
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow_flag <= 1'b0;
    end else if (pwm_mode ? top_tick : (tick_i && at_max && !at_top)) begin
      overflow_flag <= 1'b1;
    end else if (clr_ovf) begin
      overflow_flag <= 1'b0;
    end
  end

  // capture register as top reports its top through the capture flag
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_flag <= 1'b0;
    end else if (top_tick && top_is_capt(waveform_mode_select)) begin
      capture_flag <= 1'b1; // no output mode term here
    end else if (clr_capt) begin
      capture_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare channels; compare a as top flags its top by its own match
  timer16_compare_channel #(
    .WIDTH(WIDTH),
    .TOGGLE_IN_PWM(1)
  ) u_chan_a (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(tick_i),
    .count_i(counter_value),
    .pwm_i(pwm_mode),
    .top_tick_i(top_tick),
    .block_i(block_match),
    .mode_i(channel_a_output_mode),
    .force_i(force_a),
    .cmp_wr_i(wr_i && sel_cmp_a),
    .cmp_wdata_i(wdata_i),
    .flag_clr_i(clr_cmpa),
    .cmp_buf_o(cmp_a_buf),
    .cmp_act_o(cmp_a_act),
    .match_o(match_a),
    .flag_o(compare_a_flag),
    .latch_o(channel_a_output_latch)
  );

  timer16_compare_channel #(
    .WIDTH(WIDTH),
    .TOGGLE_IN_PWM(0)
  ) u_chan_b (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_i(tick_i),
    .count_i(counter_value),
    .pwm_i(pwm_mode),
    .top_tick_i(top_tick),
    .block_i(block_match),
    .mode_i(channel_b_output_mode),
    .force_i(force_b),
    .cmp_wr_i(wr_i && sel_cmp_b),
    .cmp_wdata_i(wdata_i),
    .flag_clr_i(clr_cmpb),
    .cmp_buf_o(cmp_b_buf),
    .cmp_act_o(cmp_b_act),
    .match_o(match_b),
    .flag_o(compare_b_flag),
    .latch_o(channel_b_output_latch)
  );

  //////////////////////////////////////////////////////////////////////////
  // pin override: output mode picks the source, direction bit the drive
  assign pin_a_o = (channel_a_output_mode != `T16_COM_OFF) ?
                   channel_a_output_latch : port_data_a;
  assign pin_b_o = (channel_b_output_mode != `T16_COM_OFF) ?
                   channel_b_output_latch : port_data_b;
  assign pin_a_oe_n_o = !output_pin_direction_bit_a;
  assign pin_b_oe_n_o = !output_pin_direction_bit_b;

  assign overflow_flag_o = overflow_flag;
  assign compare_a_flag_o = compare_a_flag;
  assign compare_b_flag_o = compare_b_flag;
  assign capture_flag_o = capture_flag;

  // pin readback crosses from outside, so two flops first
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_a_meta <= 1'b0;
      pin_a_sync <= 1'b0;
      pin_b_meta <= 1'b0;
      pin_b_sync <= 1'b0;
    end else begin
      pin_a_meta <= pin_a_i;
      pin_a_sync <= pin_a_meta;
      pin_b_meta <= pin_b_i;
      pin_b_sync <= pin_b_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= {WIDTH{1'b0}};
    end else if (rd_i) begin
      case (addr_i)
        `T16_ADDR_CTRL: begin
          rdata_o <= {{(WIDTH-8){1'b0}}, channel_b_output_mode,
                      channel_a_output_mode, waveform_mode_select};
        end
        `T16_ADDR_COUNT: begin
          rdata_o <= counter_value;
        end
        `T16_ADDR_CMP_A: begin
          rdata_o <= cmp_a_buf; // software sees the buffer in pwm modes
        end
        `T16_ADDR_CMP_B: begin
          rdata_o <= cmp_b_buf;
        end
        `T16_ADDR_CAPT: begin
          rdata_o <= capture_value;
        end
        `T16_ADDR_FLAGS: begin
          rdata_o <= {{(WIDTH-4){1'b0}}, capture_flag, compare_b_flag,
                      compare_a_flag, overflow_flag};
        end
        `T16_ADDR_PORT: begin
          rdata_o <= {{(WIDTH-4){1'b0}}, output_pin_direction_bit_b, port_data_b,
                      output_pin_direction_bit_a, port_data_a};
        end
        `T16_ADDR_STATUS: begin
          rdata_o <= {{(WIDTH-6){1'b0}}, match_b, match_a, pin_b_sync, pin_a_sync,
                      channel_b_output_latch, channel_a_output_latch};
        end
        default: begin
          rdata_o <= {WIDTH{1'b0}};
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [bench/pin_load.sv]
// pin load model fed from the timer pin drive and enable
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input wire logic clk_i,
  input wire logic drv_i,
  input wire logic oe_n_i,
  output logic pin_o
);
  logic last = 1'b0;
  // remember the last driven level while the timer drives the pin
  always @(posedge clk_i) begin
    last <= oe_n_i ? last : drv_i;
  end
  // no pull resistor: a released pin reads the inverse, so stale readback shows
  assign pin_o = oe_n_i ? ~last : drv_i;
endmodule
`default_nettype wire

// [bench/timer16_waveform_chk.sv]
// port assertions of the 16-bit waveform timer
`timescale 1ns/1ps
`default_nettype none
module timer16_waveform_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic overflow_serviced_i,
  input wire logic overflow_flag_o,
  input wire logic compare_a_flag_o,
  input wire logic capture_flag_o,
  input wire logic pin_a_o,
  input wire logic pin_a_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  // flags only move on timer ticks or on clears
  ovf_tick_a: assert property (disable iff (!nrst_i)
    $rose(overflow_flag_o) |-> $past(tick_i)) else $error("overflow set off tick");
  cmp_tick_a: assert property (disable iff (!nrst_i)
    $rose(compare_a_flag_o) |-> $past(tick_i)) else $error("compare set off tick");
  capt_tick_a: assert property (disable iff (!nrst_i)
    $rose(capture_flag_o) |-> $past(tick_i)) else $error("capture set off tick");
  ovf_keep_a: assert property (disable iff (!nrst_i)
    $fell(overflow_flag_o) |-> $past(overflow_serviced_i || wr_i && addr_i == 8'h06
    && wdata_i[0])) else $error("overflow cleared by itself");
  ovf_clear_a: assert property (disable iff (!nrst_i)
    overflow_serviced_i && !tick_i |=> !overflow_flag_o) else $error("overflow kept");
  // pin drive follows register writes and ticks only
  dir_hold_a: assert property (disable iff (!nrst_i)
    !$stable(pin_a_oe_n_o) |-> $past(wr_i && addr_i == 8'h07)) else $error("enable moved");
  pin_hold_a: assert property (disable iff (!nrst_i)
    !$stable(pin_a_o) |-> $past(tick_i || wr_i)) else $error("pin moved");
  force_flag_a: assert property (disable iff (!nrst_i)
    wr_i && addr_i == 8'h01 && !tick_i |=> !$rose(compare_a_flag_o))
    else $error("force set a flag");
  rst_latch_a: assert property (!nrst_i |-> !pin_a_o && pin_a_oe_n_o)
    else $error("pin active in reset");
endmodule
bind timer16_waveform timer16_waveform_chk u_chk (.clk_i, .nrst_i, .tick_i, .addr_i,
  .wdata_i, .wr_i, .overflow_serviced_i, .overflow_flag_o, .compare_a_flag_o,
  .capture_flag_o, .pin_a_o, .pin_a_oe_n_o);
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the 16-bit waveform timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 0, nrst_i = 1, tick_i = 0, wr_i = 0, rd_i = 0, rdq = 0, sv_o = 0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, rdata_o, r, t;
  logic ovf, cfa, cfb, cfc, pao, pae, pbo, pbe, pai, pbi, la, lb;
  logic [1:0] m;
  logic [3:0] m4;
  logic [15:0] q[$];
  int num_errors = 0, comparisons = 0, seed = 32'hd7b733ca, i, k, c;
  timer16_waveform u_timer16_waveform (.clk_i, .nrst_i, .tick_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .overflow_serviced_i(sv_o), .compare_a_serviced_i(1'b0),
    .compare_b_serviced_i(1'b0), .capture_serviced_i(1'b0), .overflow_flag_o(ovf),
    .compare_a_flag_o(cfa), .compare_b_flag_o(cfb), .capture_flag_o(cfc),
    .pin_a_i(pai), .pin_a_o(pao), .pin_a_oe_n_o(pae), .pin_b_i(pbi), .pin_b_o(pbo),
    .pin_b_oe_n_o(pbe));
  pin_load u_pin_load_a (.clk_i, .drv_i(pao), .oe_n_i(pae), .pin_o(pai));
  pin_load u_pin_load_b (.clk_i, .drv_i(pbo), .oe_n_i(pbe), .pin_o(pbi));
  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one register cycle; a read leaves its expectation in the queue
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    if (!w) q.push_back(d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
  endtask
  task automatic ticks(input int n);
    @(posedge clk_i);
    tick_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    tick_i <= 1'b0;
    #1;
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read data are checked in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rdq) chk(rdata_o, q.pop_front());
    rdq <= rd_i;
  end
  // hang guard, well past the longest run
  initial begin
    #450000;
    num_errors++;
    print_verdict;
  end
  initial begin
    // a real falling edge loads every async-reset flop before the first clock
    #1 nrst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk(pao, 0);
    chk(pae, 1);
    acc(1, 8'h07, 16'h000a);
    chk(pbe, 0);
    acc(0, 8'h20, 16'h0000);
    acc(0, 8'h01, 16'h0000);
    acc(0, 8'h08, 16'h0000);
    // random counts with an output mode set beside them
    acc(1, 8'h00, 16'h0030);
    for (i = 0; i < 4; i++) begin
      r = $random(seed) & 16'h7fff;
      c = 1 + ($random(seed) & 7);
      acc(1, 8'h02, r);
      ticks(c);
      acc(0, 8'h02, r + c);
    end
    acc(1, 8'h02, 16'hfffd);
    ticks(2);
    chk(ovf, 0);
    ticks(1);
    chk(ovf, 1);
    acc(0, 8'h02, 16'h0000);
    @(posedge clk_i);
    sv_o <= 1'b1;
    @(posedge clk_i);
    sv_o <= 1'b0;
    #1;
    chk(ovf, 0);
    // every output mode through the force strobe
    la = 0;
    for (i = 0; i < 5; i++) begin
      m = (i < 4) ? 3 - i : 1;
      la = (m == 3) ? 1 : (m == 2) ? 0 : (m == 1) ? !la : la;
      acc(1, 8'h00, {m, 4'h0});
      acc(1, 8'h01, 16'h0001);
      repeat (2) @(posedge clk_i);
      acc(0, 8'h08, {13'h0000, m != 0 && la, 1'b0, la});
      chk(pao, m != 0 && la);
    end
    acc(1, 8'h07, 16'h0008);
    acc(1, 8'h00, 16'h0030);
    acc(1, 8'h01, 16'h0001);
    chk(pae, 1);
    acc(1, 8'h07, 16'h000a);
    chk(pao, 1);
    chk(pae, 0);
    acc(0, 8'h06, 16'h0000);
    // clear-on-match toggle, half period of one plus the compare value
    la = 1;
    acc(1, 8'h03, 16'h0002);
    acc(1, 8'h02, 16'h0000);
    acc(1, 8'h00, 16'h0014);
    for (i = 0; i < 3; i++) begin
      ticks(2);
      chk(cfa, 0);
      ticks(1);
      la = !la;
      chk(cfa, 1);
      chk(pao, la);
      acc(0, 8'h02, 16'h0000);
      acc(1, 8'h06, 16'h0002);
    end
    chk(ovf, 0);
    acc(1, 8'h02, 16'h0005);
    ticks(16'hfffb);
    chk(ovf, 1);
    chk(cfa, 0);
    ticks(3);
    chk(cfa, 1);
    // fast pwm on channel b, top from compare a, both polarities
    acc(1, 8'h00, 16'h0000);
    acc(1, 8'h03, 16'h0007);
    acc(1, 8'h04, 16'h0003);
    acc(1, 8'h02, 16'h0000);
    acc(1, 8'h06, 16'h000f);
    c = 0;
    lb = 0;
    for (i = 2; i < 4; i++) begin
      acc(1, 8'h00, {i[1:0], 6'h0f});
      for (k = 0; k < 12; k++) begin
        ticks(1);
        if (c == 3) lb = (i == 2);
        if (c == 7) lb = (i == 3);
        c = (c == 7) ? 0 : c + 1;
        chk(pbo, lb);
      end
    end
    chk(cfb, 1);
    chk(ovf, 1);
    acc(1, 8'h01, 16'h0002);
    chk(pbo, lb);
    // fixed and capture tops, two ticks from one below the top
    acc(1, 8'h05, 16'h0009);
    for (i = 0; i < 5; i++) begin
      m4 = (i < 3) ? 5 + i : (i == 3) ? 14 : 12;
      t = (i == 0) ? 16'h00ff : (i == 1) ? 16'h01ff : (i == 2) ? 16'h03ff : 16'h0009;
      acc(1, 8'h00, {4'h0, m4});
      acc(1, 8'h02, t - 1);
      acc(1, 8'h06, 16'h000f);
      ticks(2);
      chk(cfc, m4 >= 12);
      acc(0, 8'h02, 16'h0000);
      acc(0, 8'h06, {m4 >= 12, 2'b00, m4 != 12});
    end
    repeat (3) @(posedge clk_i);
    print_verdict;
  end
endmodule
`default_nettype wire
